// *** logic/dcc_ctrl.sv ***
// Command side of the DDR controller: register port, init sequence, read/write
// command encoding, write latency and masking, refresh trigger, read buffer.
// Assumes the memory clock arrives as a pin slower than i_clk and is sampled here.
`timescale 1ns/10ps
module dcc_ctrl import dcc_pkg::*; (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  // Register port
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [63:0]        i_reg_addr,
  input  wire logic [63:0]        i_reg_wdata,
  output logic [63:0]             o_reg_rdata,
  output logic                    o_reg_rvalid,
  // Access requests
  input  wire logic               i_req_valid,
  input  wire dcc_req_t           i_req,
  output logic                    o_req_ready,
  // Read bursts out
  output logic                    o_rd_valid,
  output logic [BURST_W-1:0]      o_rd_data,
  input  wire logic               i_rd_ready,
  // Memory side
  input  wire logic               i_mem_clk,
  output dcc_cmd_t                o_cmd,
  input  wire logic [DQ_W-1:0]    i_dq,
  output logic [DQ_W-1:0]         o_dq,
  output logic                    o_dq_oe,
  output logic [DQM_W-1:0]        o_dqm,
  output logic                    o_dqs,
  output logic                    o_dqs_oe
);

  dcc_state_t         state_q, state_d;
  dcc_cmd_t           cmd_q, cmd_d;
  dcc_req_t           req_q, req_d;
  logic [63:0]        cfg_q;
  logic               start_q, done_q, done_d;
  logic               ref_pend_q, ref_due_q, ref_due_d, ref_issue;
  logic               gap_q, gap_d;
  logic [4:0]         cnt_q, cnt_d, pre_q, pre_d;
  logic [2:0]         step_q, step_d, last_bank_q, last_bank_d;
  logic [BURST_W-1:0] rdata_q, rdata_d;
  logic               push_q, push_d;
  logic [DQ_W-1:0]    dq_q, dq_d;
  logic               oe_q, oe_d, dqs_q, dqs_d;
  logic [DQM_W-1:0]   dqm_q, dqm_d;
  logic               mclk_s1, mclk_s2, mclk_s3;
  logic [DQ_W-1:0]    dq_s1, dq_s2;
  logic               tick;
  logic               buf_in_ready;
  logic [2:0]         wbeat, rbeat;

  // Pin synchronisers; mclk_s1 and dq_s1 feed only the next stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {mclk_s1, mclk_s2, mclk_s3} <= 3'h0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      {mclk_s1, mclk_s2, mclk_s3} <= {i_mem_clk, mclk_s1, mclk_s2};
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
    end
  end
  assign tick = mclk_s2 && !mclk_s3;  // One-cycle enable per link rising edge

  // Register decode over the fixed window
  logic hit_cfg, hit_init, wr_cfg, wr_init, trig_wr;
  assign hit_cfg  = (i_reg_addr == REG_BASE + OFF_CFG_ZERO);
  assign hit_init = (i_reg_addr == REG_BASE + OFF_INIT_CTRL);
  assign wr_cfg   = i_reg_wr && hit_cfg;
  assign wr_init  = i_reg_wr && hit_init;
  assign trig_wr  = wr_cfg && i_reg_wdata[BIT_REF_TRIG];

  // Live configuration bits
  logic conc_en, split_en, ref_cmd_bnd;
  assign conc_en     = cfg_q[BIT_CONC_PRE];
  assign split_en    = cfg_q[BIT_SPLIT];
  assign ref_cmd_bnd = cfg_q[BIT_REF_MODE];

  // Register file; only parameter bits are stored, so reserved bits stay inert
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q      <= CFG_ZERO_RESET;
      start_q    <= 1'b0;
      ref_pend_q <= 1'b0;
    end else begin
      if (wr_cfg) cfg_q <= i_reg_wdata & CFG_ZERO_MASK;
      if (wr_init && i_reg_wdata[BIT_START]) start_q <= 1'b1;
      ref_pend_q <= trig_wr || (ref_pend_q && !ref_issue);     // set wins
    end
  end

  // Read answer one cycle after the strobe; unmapped reads give zero
  logic [63:0] init_word;
  assign init_word = (64'(start_q) << BIT_START) | (64'(done_q) << BIT_INIT_DONE);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= 64'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata  <= !i_reg_rd ? 64'h0 : hit_cfg ? cfg_q : hit_init ? init_word : 64'h0;
    end
  end

  // Request gating: refresh at command boundary goes ahead of waiting requests
  logic pre_ok, ref_block;
  assign pre_ok      = (pre_q == 5'h00) || (conc_en && i_req.ba != last_bank_q);
  assign ref_block   = ref_pend_q && (ref_cmd_bnd || ref_due_q);
  assign o_req_ready = (state_q == ST_IDLE) && done_q && pre_ok && !gap_q && !ref_block
                       && (i_req.write || buf_in_ready);
  assign ref_issue   = (state_q == ST_IDLE) && tick && ref_pend_q && pre_q == 5'h00
                       && (ref_block || !i_req_valid);
  assign wbeat       = 3'(cnt_d - WRITE_LAT);
  assign rbeat       = 3'(cnt_q - READ_LAT - 5'h01);

  // Init step commands: precharge all, two refreshes, mode load
  function automatic dcc_cmd_t init_cmd(input logic [2:0] step);
    dcc_cmd_t c;
    c = '{cs_n: 1'b0, rcw: CMD_PRE, ba: 3'h0, addr: 15'h0400};
    if (step == 3'h1 || step == 3'h2) c.rcw = CMD_REF;
    if (step == 3'h3) begin
      c.rcw  = CMD_MRS;
      c.addr = MODE_WORD;
    end
    return c;
  endfunction

  // Sequencer; pin-facing state only moves on link ticks
  always_comb begin
    state_d = state_q;  cmd_d = cmd_q;  req_d = req_q;  cnt_d = cnt_q;
    pre_d = pre_q;  step_d = step_q;  done_d = done_q;  gap_d = gap_q;
    last_bank_d = last_bank_q;  rdata_d = rdata_q;  ref_due_d = ref_due_q;
    push_d = push_q && !buf_in_ready;
    dq_d = dq_q;  oe_d = oe_q;  dqm_d = dqm_q;  dqs_d = dqs_q;
    if (tick) begin
      cmd_d = CMD_IDLE;  // Commands last one link period
      gap_d = 1'b0;
      if (pre_q != 5'h00) pre_d = pre_q - 5'h01;
    end
    if (ref_issue) begin
      cmd_d     = '{cs_n: 1'b0, rcw: CMD_REF, ba: 3'h0, addr: 15'h0000};
      ref_due_d = 1'b0;
    end
    unique case (state_q)
      ST_OFF: if (start_q) begin  // held here until start
        state_d = ST_INIT;
        cnt_d   = INIT_WAIT;
        step_d  = 3'h0;
      end
      ST_INIT: if (tick) begin
        if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end else begin
          cmd_d  = init_cmd(step_q);
          cnt_d  = STEP_GAP;
          step_d = step_q + 3'h1;
          if (step_q == INIT_STEPS - 3'h1) begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
          end
        end
      end
      ST_IDLE: if (i_req_valid && o_req_ready) begin
        req_d   = i_req;
        state_d = ST_ACT;
      end
      ST_ACT: if (tick) begin
        cmd_d   = '{cs_n: 1'b0, rcw: CMD_ACT, ba: req_q.ba, addr: req_q.row};
        state_d = ST_CMD;
      end
      ST_CMD: if (tick) begin  // Column command with auto-precharge on addr[10]
        cmd_d   = '{cs_n: 1'b0, rcw: req_q.write ? CMD_WR : CMD_RD, ba: req_q.ba,
                    addr: {4'h0, 1'b1, req_q.col}};
        cnt_d   = 5'h00;
        state_d = ST_DATA;
      end
      ST_DATA: if (tick) begin
        cnt_d = cnt_q + 5'h01;
        oe_d  = req_q.write && cnt_d >= WRITE_LAT && cnt_d < WRITE_LAT + BURST_LEN;
        dq_d  = oe_d ? req_q.wdata[{wbeat, 4'h0} +: DQ_W] : '0;
        dqm_d = oe_d ? req_q.wmask[{wbeat, 1'b0} +: DQM_W] : '1;
        dqs_d = oe_d && cnt_d[0];
        if (!req_q.write && cnt_q > READ_LAT && cnt_q <= LAST_CNT) begin
          rdata_d[{rbeat, 4'h0} +: DQ_W] = dq_s2;
        end
        if (cnt_q == LAST_CNT) begin
          state_d     = ST_IDLE;
          pre_d       = PRE_WAIT;
          last_bank_d = req_q.ba;
          gap_d       = !split_en;
          ref_due_d   = ref_pend_q && !ref_cmd_bnd;  // burst boundary
          push_d      = !req_q.write;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_OFF;  cmd_q <= CMD_IDLE;  req_q <= '0;  cnt_q <= 5'h00;
      pre_q <= 5'h00;  step_q <= 3'h0;  done_q <= 1'b0;  gap_q <= 1'b0;
      last_bank_q <= 3'h0;  rdata_q <= '0;  ref_due_q <= 1'b0;  push_q <= 1'b0;
      dq_q <= '0;  oe_q <= 1'b0;  dqm_q <= '1;  dqs_q <= 1'b0;
    end else begin
      state_q <= state_d;  cmd_q <= cmd_d;  req_q <= req_d;  cnt_q <= cnt_d;
      pre_q <= pre_d;  step_q <= step_d;  done_q <= done_d;  gap_q <= gap_d;
      last_bank_q <= last_bank_d;  rdata_q <= rdata_d;  ref_due_q <= ref_due_d;
      push_q <= push_d;  dq_q <= dq_d;  oe_q <= oe_d;  dqm_q <= dqm_d;  dqs_q <= dqs_d;
    end
  end

  // Pin outputs straight from flops
  assign o_cmd    = cmd_q;
  assign o_dq     = dq_q;
  assign o_dq_oe  = oe_q;
  assign o_dqm    = dqm_q;
  assign o_dqs    = dqs_q;
  assign o_dqs_oe = oe_q;

  // Reads start only while buf_in_ready is high; with conc_en and split_en one can start as the buffer fills, and a write end drops its held push
  dcc_buf2 #(.W(BURST_W)) u_rbuf (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push_q),
    .i_in_data   (rdata_q),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_rd_valid),
    .o_out_data  (o_rd_data),
    .i_out_ready (i_rd_ready)
  );

  // Checks
  AST_READ_ENC: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_CMD && tick && !req_q.write) |=> (!o_cmd.cs_n && o_cmd.rcw == CMD_RD))
    else $error("read command encoding wrong");
  AST_WRITE_ENC: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_CMD && tick && req_q.write) |=> (!o_cmd.cs_n && o_cmd.rcw == CMD_WR))
    else $error("write command encoding wrong");
  AST_DQM_IDLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_dq_oe |-> (o_dqm == 2'h3 && !o_dqs_oe))
    else $error("byte mask not idle outside write data");
  AST_WL_START: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_dq_oe) |-> (cnt_q == WRITE_LAT && req_q.write))
    else $error("write data not at write latency");
  AST_CFG_RESET: assert property (@(posedge i_clk)
    !i_reset_n |-> (cfg_q == CFG_ZERO_RESET && !start_q))
    else $error("configuration not at reset value");
  AST_INIT_LAUNCH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(start_q) |-> ##[1:200] (!o_cmd.cs_n && o_cmd.rcw == 3'h2))
    else $error("init sequence did not begin");
  AST_NO_EARLY_ACCESS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_req_ready |-> (done_q && start_q))
    else $error("access allowed before init done");
  AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_reg_rd && hit_cfg) |=> ((o_reg_rdata & ~CFG_ZERO_MASK) == 64'h0))
    else $error("reserved bits read nonzero");
  AST_PRE_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!conc_en && pre_q != 5'h00) |-> !o_req_ready)
    else $error("request taken during auto-precharge");
  AST_REFRESH_SENT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(ref_pend_q) |-> ##[1:1000] (!o_cmd.cs_n && o_cmd.rcw == 3'h1))
    else $error("refresh trigger not served");
  AST_QUIET_BEFORE_START: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !start_q |-> (o_cmd.cs_n && !o_req_ready && !o_dq_oe))
    else $error("activity before start");

endmodule

// *** logic/dcc_pkg.sv ***
// Package for the DDR command and init controller: register map, field positions,
// link timing in link-clock periods, command codes and the carrier structs.
// Assumes a 64-bit register port and one SDRAM rank with 16 data lines.
package dcc_pkg;

  // Register window and offsets
  localparam logic [63:0] REG_BASE      = 64'h0000_0000_0ff0_0000;
  localparam logic [63:0] OFF_CFG_ZERO  = 64'h0000_0000_0000_0000;
  localparam logic [63:0] OFF_INIT_CTRL = 64'h0000_0000_0000_0030;

  // Field positions
  localparam int BIT_CONC_PRE  = 48;
  localparam int BIT_SPLIT     = 40;
  localparam int BIT_REF_MODE  = 32;
  localparam int BIT_REF_TRIG  = 24;
  localparam int BIT_START     = 0;
  localparam int BIT_INIT_DONE = 8;

  // Reset value and the bits that carry a parameter
  localparam logic [63:0] CFG_ZERO_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CFG_ZERO_MASK  = 64'h0001_0101_0000_0000;

  // Link timing, counted in link-clock periods
  localparam logic [4:0] READ_LAT   = 5'h03;
  localparam logic [4:0] WRITE_LAT  = READ_LAT - 5'h01;
  localparam logic [4:0] BURST_LEN  = 5'h08;
  localparam logic [4:0] LAST_CNT   = READ_LAT + BURST_LEN;
  localparam logic [4:0] PRE_WAIT   = 5'h02;
  localparam logic [4:0] INIT_WAIT  = 5'h04;
  localparam logic [4:0] STEP_GAP   = 5'h02;
  localparam logic [2:0] INIT_STEPS = 3'h4;
  localparam logic [14:0] MODE_WORD = 15'h0033;

  // Data path widths
  localparam int DQ_W    = 16;
  localparam int DQM_W   = 2;
  localparam int BURST_W = 128;
  localparam int MASK_W  = 16;

  // Command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;

  typedef struct packed {
    logic        cs_n;
    logic [2:0]  rcw;
    logic [2:0]  ba;
    logic [14:0] addr;
  } dcc_cmd_t;

  typedef struct packed {
    logic               write;
    logic [2:0]         ba;
    logic [14:0]        row;
    logic [9:0]         col;
    logic [BURST_W-1:0] wdata;
    logic [MASK_W-1:0]  wmask;
  } dcc_req_t;

  typedef enum logic [2:0] {ST_OFF, ST_INIT, ST_IDLE, ST_ACT, ST_CMD, ST_DATA} dcc_state_t;

  localparam dcc_cmd_t CMD_IDLE = '{cs_n: 1'b1, rcw: CMD_NOP, ba: 3'h0, addr: 15'h0000};

endpackage

// *** logic/dcc_buf2.sv ***
// Two-entry valid/ready buffer for assembled read bursts.
// Assumes both sides on i_clk; the source watches o_in_ready.
`timescale 1ns/10ps
module dcc_buf2 import dcc_pkg::*; #(
  parameter int W = BURST_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // Filling side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Draining side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // Honest full and empty from the occupancy count
  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = mem_q[rp_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointers and count
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) mem_q[wp_q] <= i_in_data;
  end

endmodule

// *** tb/dcc_mem_model.sv ***
// Behavioural SDRAM partner: free-running link clock, stores write beats, returns read beats.
// Assumes one access at a time and each command standing one link period.
`timescale 1ns/10ps
module dcc_mem_model import dcc_pkg::*; (
  // Link side
  output logic             o_mem_clk,
  input  wire dcc_cmd_t    i_cmd,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dq_oe,
  input  wire logic [1:0]  i_dqm,
  input  wire logic        i_dqs,
  output logic [15:0]      o_dq,
  // Observations for the bench
  output int               o_errors,
  output int               o_refs,
  output logic [11:0]      o_seq
);
  localparam int WL = WRITE_LAT;
  localparam int RL = READ_LAT;
  logic [127:0] mem [logic [27:0]];
  logic [127:0] word;
  logic [27:0]  key;
  logic [14:0]  row;
  int           n, wr_at, rd_at, d;
  // Device clock runs free, as a real part's clock does
  initial begin
    {o_dq, row, key, word} = '0;
    {o_errors, o_refs, n} = '0;
    {wr_at, rd_at} = {-32'sd100, -32'sd100};
    o_seq = 12'hfff;
    o_mem_clk = 0;
    forever #80 o_mem_clk = ~o_mem_clk;
  end
  // Commands decoded and beats moved at each rising link edge
  always @(posedge o_mem_clk) begin
    n = n + 1;
    if (i_cmd.cs_n === 1'b0) begin
      o_seq = {o_seq[8:0], i_cmd.rcw};
      if (i_cmd.rcw === CMD_REF) o_refs++;
      if (i_cmd.rcw === CMD_ACT) row = i_cmd.addr;
      if (i_cmd.rcw === CMD_WR || i_cmd.rcw === CMD_RD) begin
        key = {i_cmd.ba, row, i_cmd.addr[9:0]};
        word = mem.exists(key) ? mem[key] : '0;
        if (i_cmd.rcw === CMD_WR) wr_at = n;
        else rd_at = n;
      end
    end
    d = n - wr_at;
    if (d == WL - 1 && i_dq_oe !== 1'b0) o_errors++;
    if (d >= WL && d < WL + 8) begin
      if (i_dq_oe !== 1'b1) o_errors++;
      if (i_dqs !== 1'(d - WL)) o_errors++;
      for (int b = 0; b < 2; b++)
        if (i_dqm[b] === 1'b0) word[(d - WL) * 16 + b * 8 +: 8] = i_dq[b * 8 +: 8];
      mem[key] = word;
    end
    // Released lines toggle so a stale value cannot pass for data
    d = n - rd_at;
    // Beats start one period late to leave room for the controller's pin synchronisers
    if (d >= RL + 1 && d < RL + 9) o_dq = word[(d - RL - 1) * 16 +: 16];
    else o_dq = ~o_dq;
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for dcc_ctrl against the SDRAM partner model.
// Assumes the init control word at OFF_INIT_CTRL, start at bit 0, done at bit 8.
`timescale 1ns/10ps
module tb_top import dcc_pkg::*;;
  logic         i_clk, i_reset_n, reg_wr, reg_rd, reg_rvalid, req_valid, req_ready;
  logic         rd_valid, rd_ready, mem_clk, dq_oe, dqs;
  logic [63:0]  reg_addr, reg_wdata, reg_rdata, r;
  logic [127:0] rd_data;
  logic [15:0]  dq_in, dq_out;
  logic [1:0]   dqm;
  logic [11:0]  seq;
  logic [27:0]  key;
  dcc_req_t     req;
  dcc_cmd_t     cmd;
  int           errors, refs, miscompares, compares, seed, hits, r0;
  bit           stall;
  logic [127:0] shadow [logic [27:0]];
  logic [127:0] rdq [$];
  logic [63:0]  regq [$];

  dcc_ctrl dcc_ctrl_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_rd_ready(rd_ready), .i_mem_clk(mem_clk), .o_cmd(cmd), .i_dq(dq_in),
    .o_dq(dq_out), .o_dq_oe(dq_oe), .o_dqm(dqm), .o_dqs(dqs), .o_dqs_oe());
  dcc_mem_model dcc_mem_model_inst (.o_mem_clk(mem_clk), .i_cmd(cmd), .i_dq(dq_out), .i_dq_oe(dq_oe),
    .i_dqm(dqm), .i_dqs(dqs), .o_dq(dq_in), .o_errors(errors), .o_refs(refs), .o_seq(seq));

  // System clock, 100 MHz
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (exp !== got) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle strobes, launched at the falling edge
  task automatic reg_access(input bit wr, input logic [63:0] off, input logic [63:0] data);
    @(negedge i_clk);
    {reg_wr, reg_rd} = {wr, !wr};
    reg_addr = REG_BASE + off;
    reg_wdata = data;
    if (!wr) regq.push_back(data);
    @(negedge i_clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask

  // Request held until seen taken; the shadow copy predicts later reads
  task automatic mem_req(input bit wr, input logic [27:0] k);
    logic [127:0] data;
    logic [15:0]  mask;
    logic [127:0] old;
    data = {$random(seed), $random(seed), $random(seed), $random(seed)};
    mask = 16'($random(seed));
    old = shadow.exists(k) ? shadow[k] : '0;
    @(negedge i_clk);
    req_valid = 1;
    req = '{write: wr, ba: k[27:25], row: k[24:10], col: k[9:0], wdata: data, wmask: mask};
    #1;
    for (int i = 0; i < 3000 && req_ready !== 1'b1; i++) begin
      @(negedge i_clk);
      #1;
    end
    check("request taken", 1'b1, req_ready);
    @(negedge i_clk);
    req_valid = 0;
    for (int b = 0; b < 16; b++)
      if (wr && !mask[b]) old[b * 8 +: 8] = data[b * 8 +: 8];
    if (wr) shadow[k] = old;
    else rdq.push_back(old);
  endtask

  task automatic drain;
    for (int i = 0; i < 5000 && rdq.size() > 0; i++) @(negedge i_clk);
  endtask

  // Answers checked against the oldest note; receiver readiness is random
  always @(negedge i_clk) begin
    if (reg_rvalid === 1'b1) check("reg rdata", regq.pop_front(), reg_rdata);
    // Ready is chosen first so the check matches the burst taken at the next rising edge
    rd_ready = !stall && ($random(seed) & 1) != 0;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) check("read burst", rdq.pop_front(), rd_data);
  end

  initial begin
    seed = 32'h48f8;
    {miscompares, compares, stall, reg_wr, reg_rd, req_valid} = '0;
    // Reset falls after time zero so the asynchronous reset edge is never missed
    i_reset_n = 1'b1;
    #1 i_reset_n = 1'b0;
    {reg_addr, reg_wdata, req} = '0;
    repeat (20) @(negedge i_clk);
    check("cmd in reset", CMD_IDLE, cmd);
    i_reset_n = 1;
    reg_access(0, OFF_CFG_ZERO, CFG_ZERO_RESET);
    reg_access(0, OFF_INIT_CTRL, 64'h0);
    reg_access(0, -64'h10, 64'h0);
    // Requests before start are refused and the command lines stay quiet
    req_valid = 1;
    hits = 0;
    repeat (300) begin
      @(negedge i_clk);
      if (req_ready !== 1'b0) hits++;
    end
    req_valid = 0;
    check("early ready", 0, hits);
    r = {$random(seed), $random(seed)} & ~64'h0100_0000;
    reg_access(1, OFF_CFG_ZERO, r);
    reg_access(0, OFF_CFG_ZERO, r & CFG_ZERO_MASK);
    reg_access(1, OFF_INIT_CTRL, {$random(seed), $random(seed)} & ~64'h1);
    reg_access(0, OFF_INIT_CTRL, 64'h0);
    check("cmds before start", 12'hfff, seq);
    reg_access(1, OFF_INIT_CTRL, 64'h1);
    for (int i = 0; i < 2000 && seq !== {CMD_PRE, CMD_REF, CMD_REF, CMD_MRS}; i++) @(negedge i_clk);
    check("init sequence", {CMD_PRE, CMD_REF, CMD_REF, CMD_MRS}, seq);
    repeat (100) @(negedge i_clk);
    reg_access(0, OFF_INIT_CTRL, 64'h101);
    // Every setting of the three behaviour bits, with traffic and a refresh
    for (int m = 0; m < 8; m++) begin
      r = {15'h0, m[2], 7'h0, m[1], 7'h0, m[0], 32'h0};
      reg_access(1, OFF_CFG_ZERO, r);
      reg_access(0, OFF_CFG_ZERO, r);
      // Refresh pending while traffic starts, so the boundary mode decides its place
      r0 = refs;
      reg_access(1, OFF_CFG_ZERO, r | 64'h0100_0000);
      for (int i = 0; i < 4; i++) begin
        key = 28'($random(seed));
        mem_req(1, key);
        mem_req(1, key);
        mem_req(0, key);
        mem_req(0, key ^ 28'h200_0000);
      end
      drain;
      repeat (300) @(negedge i_clk);
      check("refresh count", r0 + 1, refs);
      reg_access(0, OFF_CFG_ZERO, r);
    end
    // Receiver stalls: two bursts fill the buffer and the third read waits
    stall = 1;
    mem_req(0, key);
    mem_req(0, key);
    repeat (400) @(negedge i_clk);
    hits = 0;
    fork
      mem_req(0, key);
      begin
        repeat (300) @(negedge i_clk) if (req_ready === 1'b1) hits++;
        stall = 0;
      end
    join
    check("ready while full", 0, hits);
    drain;
    check("model errors", 0, errors);
    check("reads left", 0, rdq.size());
    give_verdict;
  end

  // Watchdog well beyond the expected length of the run
  initial begin
    #1_000_000;
    miscompares++;
    give_verdict;
  end
endmodule
